/* rtl/tpw_map.vh */
// constants for the 8-bit timer pwm waveform block
`ifndef TPW_MAP_VH
`define TPW_MAP_VH
// register offsets
`define TPW_ADDR_CTRL 4'h0
`define TPW_ADDR_CMPV 4'h1
`define TPW_ADDR_CNT 4'h2
`define TPW_ADDR_FLAG 4'h3
`define TPW_ADDR_PRE 4'h4
// control field positions
`define TPW_CTRL_WGM_LO 0
`define TPW_CTRL_COM_LO 2
`define TPW_CTRL_RUN 4
// flag field positions
`define TPW_FLAG_OVF 0
`define TPW_FLAG_CMP 1
// waveform modes
`define TPW_WGM_NORMAL 2'h0
`define TPW_WGM_PCPWM 2'h1
`define TPW_WGM_CTC 2'h2
`define TPW_WGM_FAST 2'h3
// output actions
`define TPW_COM_NONE 2'h0
`define TPW_COM_TOGGLE 2'h1
`define TPW_COM_NONINV 2'h2
`define TPW_COM_INV 2'h3
// count limits
`define TPW_MAX 8'hff
`define TPW_BOTTOM 8'h00
// reset values
`define TPW_CTRL_RST 8'h00
`define TPW_CMPV_RST 8'h00
`define TPW_PRE_RST 8'h00
`endif

/* rtl/tpw_pwm.v */
// 8-bit timer with fast and phase-correct pwm waveform generation
// Function
// - mode 3 selects single-slope fast pwm
// - fast pwm wraps to zero after max
// - fast pwm action 2 normal, 3 inverted
// - fast: clear on match, set at wrap
// - wrap output change in same tick
// - fast pwm overflow flag at max
// - fast compare bottom gives one-tick spike
// - fast compare max gives constant level
// - fast action 1 toggles on match
// - compare value double buffered in pwm
// - mode 1 selects dual-slope phase-correct pwm
// - phase-correct reverses at max, one tick
// - phase-correct fixed eight-bit range
// - pc: clear on up match, set down
// - pc action 2 normal, 3 inverted
// - phase-correct overflow flag at bottom
// - pc extremes give constant levels
// - pc leaving max corrects held level
// - pc missed up match still transitions
// - counter advances on one-cycle tick enable
// - action 0 leaves output register alone
// - max is 0xff, bottom is zero
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "tpw_map.vh"
module tpw_pwm (
  input wire i_clock,
  input wire i_sys_rst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_port_data,
  input wire i_output_pin_direction,
  output wire o_pin,
  output wire o_pin_oe,
  output wire o_overflow_flag,
  output wire o_compare_match_flag,
  output wire o_compare_output
);
  reg [7:0] ctrl_ff;
  reg [7:0] pre_ff;
  reg [7:0] cmp_buf_ff;
  reg [7:0] compare_value_ff;
  reg [7:0] count_value_ff;
  reg down_ff;
  reg compare_output_ff;
  reg ovf_ff;
  reg cmf_ff;
  reg blk_ff;
  reg [7:0] nxt_count;
  reg nxt_down;
  reg nxt_oc;
  reg nxt_load;
  reg ev_ovf;
  reg ev_cmp;
  wire timer_tick;
  wire [1:0] waveform_mode_select;
  wire [1:0] compare_output_action;
  wire is_pwm;
  wire match;
  wire wr_ctrl;
  wire wr_cmpv;
  wire wr_cnt;
  wire wr_flag;
  wire wr_pre;
  //////////////////////////////////////////////////////////////////////
  // field decode and write strobes
  assign waveform_mode_select = ctrl_ff[`TPW_CTRL_WGM_LO+1:`TPW_CTRL_WGM_LO];
  assign compare_output_action = ctrl_ff[`TPW_CTRL_COM_LO+1:`TPW_CTRL_COM_LO];
  assign is_pwm = waveform_mode_select[0];
  assign wr_ctrl = i_wr && (i_addr == `TPW_ADDR_CTRL);
  assign wr_cmpv = i_wr && (i_addr == `TPW_ADDR_CMPV);
  assign wr_cnt = i_wr && (i_addr == `TPW_ADDR_CNT);
  assign wr_flag = i_wr && (i_addr == `TPW_ADDR_FLAG);
  assign wr_pre = i_wr && (i_addr == `TPW_ADDR_PRE);
  // a counter write blocks the match of the next tick
  assign match = (count_value_ff == compare_value_ff) && !blk_ff;
  //////////////////////////////////////////////////////////////////////
  // tick enable from divider
  tpw_tick_div u_div (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_run(ctrl_ff[`TPW_CTRL_RUN]),
    .i_div(pre_ff),
    .o_tick(timer_tick)
  );
  //////////////////////////////////////////////////////////////////////
  // next count, direction, output and events per tick
  always @* begin
    nxt_count = count_value_ff;
    nxt_down = down_ff;
    nxt_oc = compare_output_ff;
    nxt_load = 1'b0;
    ev_ovf = 1'b0;
    ev_cmp = match;
    case (waveform_mode_select)
      `TPW_WGM_FAST: begin
        nxt_down = 1'b0;
        if (count_value_ff == `TPW_MAX) begin
          nxt_count = `TPW_BOTTOM;
          nxt_load = 1'b1;
        end else begin
          nxt_count = count_value_ff + 8'h01;
        end
        ev_ovf = (count_value_ff == `TPW_MAX);
        case (compare_output_action)
          `TPW_COM_TOGGLE: begin
            if (match) nxt_oc = ~compare_output_ff;
          end
          `TPW_COM_NONINV: begin
            if (match) nxt_oc = 1'b0;
            else if (count_value_ff == `TPW_MAX) nxt_oc = 1'b1;
          end
          `TPW_COM_INV: begin
            if (match) nxt_oc = 1'b1;
            else if (count_value_ff == `TPW_MAX) nxt_oc = 1'b0;
          end
          default: nxt_oc = compare_output_ff;
        endcase
      end
      `TPW_WGM_PCPWM: begin
        if (!down_ff) begin
          if (count_value_ff == `TPW_MAX) begin
            nxt_down = 1'b1;
            nxt_count = count_value_ff - 8'h01;
          end else begin
            nxt_count = count_value_ff + 8'h01;
          end
        end else begin
          if (count_value_ff == `TPW_BOTTOM) begin
            nxt_down = 1'b0;
            nxt_count = count_value_ff + 8'h01;
          end else begin
            nxt_count = count_value_ff - 8'h01;
          end
        end
        nxt_load = (count_value_ff == `TPW_MAX);
        ev_ovf = (count_value_ff == `TPW_BOTTOM);
        if (compare_output_action[1]) begin
          if (count_value_ff == `TPW_MAX) begin
            // level at max follows up-count result for the new value
            if (cmp_buf_ff == `TPW_MAX) nxt_oc = ~compare_output_action[0];
            else nxt_oc = compare_output_action[0];
          end else if (count_value_ff == `TPW_BOTTOM) begin
            // bottom compare stays at the up-count level
            if (compare_value_ff == `TPW_BOTTOM) nxt_oc = compare_output_action[0];
            else nxt_oc = ~compare_output_action[0];
          end else if (match) begin
            nxt_oc = down_ff ^ compare_output_action[0];
          end
        end
      end
      default: begin
        // non-pwm modes: plain count, no output action here
        nxt_count = count_value_ff + 8'h01;
        nxt_down = 1'b0;
        ev_ovf = (count_value_ff == `TPW_MAX);
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////
  // registers, counter and flags
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_ff <= `TPW_CTRL_RST;
      pre_ff <= `TPW_PRE_RST;
      cmp_buf_ff <= `TPW_CMPV_RST;
      compare_value_ff <= `TPW_CMPV_RST;
      count_value_ff <= `TPW_BOTTOM;
      down_ff <= 1'b0;
      compare_output_ff <= 1'b0;
      ovf_ff <= 1'b0;
      cmf_ff <= 1'b0;
      blk_ff <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_ff <= i_wdata;
      if (wr_pre) pre_ff <= i_wdata;
      if (wr_cmpv) cmp_buf_ff <= i_wdata;
      if (!is_pwm && wr_cmpv) compare_value_ff <= i_wdata;
      else if (is_pwm && timer_tick && nxt_load) compare_value_ff <= cmp_buf_ff;
      if (wr_cnt) begin
        count_value_ff <= i_wdata;
        blk_ff <= 1'b1;
      end else if (timer_tick) begin
        count_value_ff <= nxt_count;
        down_ff <= nxt_down;
        compare_output_ff <= nxt_oc;
        blk_ff <= 1'b0;
      end
      // flags: set wins over write-one clear
      ovf_ff <= (timer_tick && ev_ovf) ||
                (ovf_ff && !(wr_flag && i_wdata[`TPW_FLAG_OVF]));
      cmf_ff <= (timer_tick && ev_cmp) ||
                (cmf_ff && !(wr_flag && i_wdata[`TPW_FLAG_CMP]));
    end
  end
  //////////////////////////////////////////////////////////////////////
  // read data, one cycle after strobe
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `TPW_ADDR_CTRL: o_rdata <= ctrl_ff;
        `TPW_ADDR_CMPV: o_rdata <= cmp_buf_ff;
        `TPW_ADDR_CNT: o_rdata <= count_value_ff;
        `TPW_ADDR_FLAG: o_rdata <= {6'h00, cmf_ff, ovf_ff};
        `TPW_ADDR_PRE: o_rdata <= pre_ff;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // pin override and direction
  assign o_pin = ((compare_output_action != `TPW_COM_NONE) &&
                  !(waveform_mode_select == `TPW_WGM_PCPWM &&
                    compare_output_action == `TPW_COM_TOGGLE)) ?
                 compare_output_ff : i_port_data;
  assign o_pin_oe = i_output_pin_direction;
  assign o_overflow_flag = ovf_ff;
  assign o_compare_match_flag = cmf_ff;
  assign o_compare_output = compare_output_ff;
endmodule // tpw_pwm
`default_nettype wire

/* rtl/tpw_tick_div.v */
// timer tick divider: one-cycle enable every (div+1) clocks
`timescale 1ns/100ps
`default_nettype none
module tpw_tick_div (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_run,
  input wire [7:0] i_div,
  output reg o_tick
);
  reg [7:0] cnt_ff;
  //////////////////////////////////////////////////////////////////////
  // count down, pulse on wrap
  always @(posedge i_clock) begin
    if (i_sys_rst || !i_run) begin
      cnt_ff <= 8'h00;
      o_tick <= 1'b0;
    end else if (cnt_ff == 8'h00) begin
      cnt_ff <= i_div;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff - 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule // tpw_tick_div
`default_nettype wire

/* tb/test_tpw_pwm.sv */
// self-checking bench for the timer pwm block
`timescale 1ns/100ps
`default_nettype none
module test_tpw_pwm;
  logic i_clock, i_sys_rst, i_wr, i_rd, i_pd, i_dir;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, a, b, cv;
  wire [7:0] o_rdata;
  wire o_pin, o_oe, o_ovf, o_cmf, o_cmp;
  int errors, n_compared, e;
  logic [1:0] cur_md, cur_act;
  tpw_pwm dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_data(i_pd),
    .i_output_pin_direction(i_dir), .o_pin(o_pin), .o_pin_oe(o_oe), .o_overflow_flag(o_ovf),
    .o_compare_match_flag(o_cmf), .o_compare_output(o_cmp));
  // clock source
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] ex, input logic [7:0] g);
    n_compared++;
    if (g !== ex) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, ex, g);
    end
  endtask
  task automatic chkn(input int ex, input int g);
    n_compared++;
    if (g != ex) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, ex, g);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // configure, settle, then count high cycles and pin faults
  task automatic run(input logic [1:0] md, input logic [1:0] ac, input logic [7:0] v,
      input int st, input int n, input int ex);
    int c, m, t;
    logic ps;
    logic [7:0] q;
    c = 0;
    m = 0;
    cur_md = md;
    cur_act = ac;
    ps = ac == 2'h0 || (md == 2'h1 && ac == 2'h1);
    wr(4'h1, v);
    wr(4'h0, {3'h0, 1'b1, ac, md});
    repeat (st) @(posedge i_clock);
    repeat (n) begin
      @(posedge i_clock);
      i_pd <= 1'($urandom);
      i_dir <= 1'($urandom);
      #1;
      c += (o_cmp === 1'b1);
      m += (o_oe !== i_dir) || (o_pin !== (ps ? i_pd : o_cmp));
    end
    if (ex >= 0) chkn(ex, c);
    chkn(0, m);
    // overflow phase: clear, wait for the set, then read the count
    if (ex >= 0) begin
      wr(4'h3, 8'h01);
      #1;
      // a set in the clear cycle wins, so clear once more
      if (o_ovf) wr(4'h3, 8'h01);
      t = 0;
      do begin
        @(posedge i_clock);
        #1;
        t++;
      end while (!o_ovf && t < 600);
      if (t >= 600) begin
        errors++;
        report_and_stop();
      end else begin
        rd(4'h2, q);
        chk8((md == 2'h3) ? 8'h01 : 8'h02, q);
      end
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #5_000_000;
    errors++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_sys_rst, i_wr, i_rd, i_pd, i_dir, i_addr, i_wdata} = '0;
    i_sys_rst = 1'b1;
    void'($urandom(32'hb0cf));
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    wr(4'h9, 8'hff);
    for (int k = 0; k < 8; k++) begin
      rd((k > 4) ? 4'h9 : 4'(k), b);
      chk8(8'h00, b);
    end
    $display("test reset done");
    for (int ac = 2; ac < 4; ac++) begin
      for (int k = 0; k < 3; k++) begin
        cv = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'(1 + $urandom % 254);
        // fast: a match at max beats the wrap, so max holds the match level
        if (cv == 8'hff) e = (ac == 2) ? 0 : 256;
        else e = (ac == 2) ? cv + 1 : 255 - cv;
        run(2'h3, 2'(ac), cv, 600, 256, e);
        e = (ac == 2) ? 2 * cv : 510 - 2 * cv;
        run(2'h1, 2'(ac), cv, 1100, 510, e);
      end
    end
    run(2'h3, 2'h1, 8'h40, 600, 512, 256);
    run(2'h1, 2'h1, 8'h40, 20, 64, -1);
    run(2'h3, 2'h0, 8'h40, 20, 300, -1);
    $display("test waveforms done");
    rd(4'h3, b);
    chk8(8'h03, b);
    chk8(8'h03, {6'h00, o_cmf, o_ovf});
    wr(4'h0, 8'h00);
    repeat (5) @(posedge i_clock);
    wr(4'h3, 8'h03);
    rd(4'h3, b);
    chk8(8'h00, b);
    chk8(8'h00, {6'h00, o_cmf, o_ovf});
    $display("test flags done");
    for (int p = 0; p < 4; p += 3) begin
      wr(4'h4, 8'(p));
      wr(4'h0, 8'h13);
      rd(4'h2, a);
      repeat (38) @(posedge i_clock);
      rd(4'h2, b);
      chk8(8'(40 / (p + 1)), b - a);
    end
    $display("test prescale done");
    report_and_stop();
  end
endmodule // test_tpw_pwm
`default_nettype wire

/* tb/tpw_pwm_sva.sv */
// assertion checker for the timer pwm block
`timescale 1ns/100ps
`default_nettype none
module tpw_pwm_sva (
  input wire i_clock,
  input wire i_sys_rst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_port_data,
  input wire i_output_pin_direction,
  input wire o_pin,
  input wire o_pin_oe,
  input wire o_overflow_flag,
  input wire o_compare_match_flag,
  input wire o_compare_output
);
  reg [7:0] ctl_ff;
  wire port_sel;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // shadow of the control register
  always @(posedge i_clock) begin
    if (i_sys_rst) ctl_ff <= 8'h00;
    else if (i_wr && i_addr == 4'h0) ctl_ff <= i_wdata;
  end
  // pin taken by port logic
  assign port_sel = ctl_ff[3:2] == 2'h0 || ctl_ff[3:0] == 4'h5;
  sequence s_rd_unmapped;
    i_rd && i_addr > 4'h4;
  endsequence
  property p_unmapped;
    s_rd_unmapped |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_oe;
    o_pin_oe == i_output_pin_direction;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_pin_port;
    port_sel |-> o_pin == i_port_data;
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin not port data");
  property p_pin_cmp;
    !port_sel |-> o_pin == o_compare_output;
  endproperty
  a_pin_cmp: assert property (p_pin_cmp) else $error("pin not compare output");
  property p_hold;
    ctl_ff[3:2] == 2'h0 && $past(ctl_ff[3:2]) == 2'h0 |-> $stable(o_compare_output);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved with action 0");
  property p_ovf_fall;
    $fell(o_overflow_flag) |-> $past(i_wr && i_addr == 4'h3 && i_wdata[0]);
  endproperty
  a_ovf_fall: assert property (p_ovf_fall) else $error("overflow flag lost");
  property p_cmf_fall;
    $fell(o_compare_match_flag) |-> $past(i_wr && i_addr == 4'h3 && i_wdata[1]);
  endproperty
  a_cmf_fall: assert property (p_cmf_fall) else $error("match flag lost");
  property p_stop;
    !ctl_ff[4] && !$past(ctl_ff[4]) && !$past(ctl_ff[4], 2) && !$past(ctl_ff[4], 3)
      |-> !$rose(o_overflow_flag) && !$rose(o_compare_match_flag);
  endproperty
  a_stop: assert property (p_stop) else $error("flag set while stopped");
endmodule // tpw_pwm_sva
bind tpw_pwm tpw_pwm_sva chk_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_data(i_port_data),
  .i_output_pin_direction(i_output_pin_direction), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
  .o_overflow_flag(o_overflow_flag), .o_compare_match_flag(o_compare_match_flag),
  .o_compare_output(o_compare_output));
`default_nettype wire
